// ---- pkg/front_end_seq_regs.svh ----
/*
  Register map, field positions, reset values and timing figures of the
  front-end conversion sequencer.
  Assumes inclusion by bare name from the design file and the testbench.
*/
`ifndef FRONT_END_SEQ_REGS_SVH
`define FRONT_END_SEQ_REGS_SVH

// Byte addresses on the APB
`define OFS_MODE            32'h400B0004
`define OFS_EXT_MODE        32'h400B0008
`define OFS_SEQ_LOW         32'h400B000C
`define OFS_SEQ_HIGH        32'h400B0010
`define OFS_CHAN_SET        32'h400B0014
`define OFS_CHAN_CLR        32'h400B0018
`define OFS_CHAN_STATUS     32'h400B001C
`define OFS_LAST_RESULT     32'h400B0020
`define OFS_EVENT_STATUS    32'h400B0030
`define OFS_CMP_WINDOW      32'h400B0050
`define OFS_CHAN_GAIN       32'h400B0054
`define OFS_CHAN_DIFF       32'h400B0060
`define OFS_WPROT           32'h400B00E4

// Mode register fields
`define MODE_SETTLE_LSB     20
`define MODE_PER_CHAN_BIT   23
`define MODE_TRACK_LSB      24
`define MODE_XFER_LSB       28
`define MODE_USER_ORDER_BIT 31

// Extended mode register fields
`define EXT_CMP_MODE_LSB    0
`define EXT_CMP_CHAN_LSB    4
`define EXT_CMP_EVERY_BIT   9
`define EXT_FILTER_LSB      12
`define EXT_RES_LSB         16
`define EXT_TAG_BIT         24
`define EXT_ONE_TRIG_BIT    25
`define EXT_SIGN_LSB        28

// Status and result fields
`define STAT_DRDY_BIT       24
`define STAT_CMP_BIT        26
`define LAST_CHAN_LSB       24
`define WPROT_EN_BIT        0

// Settling periods per code
`define SETTLE_CODE0        5'd3
`define SETTLE_CODE1        5'd5
`define SETTLE_CODE2        5'd9
`define SETTLE_CODE3        5'd17

// Resolution codes, shift and result widths
`define RES_12BIT           3'd0
`define RES_10BIT           3'd1
`define RES_10BIT_SHIFT     5'd2
`define RES_10BIT_WIDTH     5'd10
`define RES_12BIT_WIDTH     5'd12
`define RES_AVG_BASE_WIDTH  5'd11

// Reset values
`define RESET_ZERO          32'h0000_0000

`endif

// ---- pkg/front_end_seq_pkg.sv ----
/*
  Types shared by the front-end conversion sequencer.
  Assumes the register header sits beside it on the include path.
*/
`default_nettype none

package front_end_seq_pkg;
  // Conversion phase, Gray coded along settle-track-transfer-store
  typedef enum logic [2:0]
  {
    ST_IDLE     = 3'b000,
    ST_SETTLE   = 3'b001,
    ST_TRACK    = 3'b011,
    ST_TRANSFER = 3'b010,
    ST_STORE    = 3'b110
  } seq_state_t;

  // Window comparison modes
  typedef enum logic [1:0]
  {
    CMP_LOW  = 2'h0,
    CMP_HIGH = 2'h1,
    CMP_IN   = 2'h2,
    CMP_OUT  = 2'h3
  } cmp_mode_t;
endpackage

`default_nettype wire

// ---- verilog/front_end_controller.sv ----
/*
  Conversion sequencer of the analog front end: configuration registers on
  APB, channel ordering, conversion timing, averaging, sign handling,
  result tagging and window comparison.
  Assumes an analog converter that holds its 12-bit result stable on
  afe_result_i by the end of the transfer phase, and a trigger pin that is
  asynchronous to core_clk_i.
*/
// The APB slave port was left to the implementer.
// Operation
// - Settling code selects 3,5,9,17 periods
// - Analog change off uses channel zero settings
// - Tracking time is field plus one; field bit 26 is masked off on write and always reads 0
// - Transfer period is twice field plus three
// - Numeric order or user sequence order
// - Protected registers ignore writes when locked
// - Two-bit compare mode: low,high,in,out
// - Compare one selected channel or all
// - Flag after filter plus one events
// - Resolution code picks width and averaging
// - Tag appends channel number, else zero
// - Single trigger completes whole averaged result
// - Sign mode picks signedness per channel type
// - Signed results extend sign to bit fifteen
// - Sixteen four-bit slots hold channel numbers
// - Slots matter only in user order
// - Disabled slot adds no conversion
// - Repeated channel sampled once per slot
// - Enable register sets channel bits
// - Disable register clears channel bits
// - User order: enable bit names slot
// - Status register shows enabled channels
`default_nettype none

`include "front_end_seq_regs.svh"

module front_end_controller
#(
  parameter int unsigned AFE_DIV = 1  // Core clocks per converter clock
)
(
  input  wire logic                            core_clk_i,
  input  wire logic                            arst_n_i,
  input  wire logic                            ce_i,
  input  wire logic                            psel_i,
  input  wire logic                            penable_i,
  input  wire logic                            pwrite_i,
  input  wire logic [31:0]                     paddr_i,
  input  wire logic [31:0]                     pwdata_i,
  output logic      [31:0]                     prdata_o,
  output logic                                 pready_o,
  output logic                                 pslverr_o,
  input  wire logic                            trigger_i,
  input  wire logic [11:0]                     afe_result_i,
  output logic      [3:0]                      afe_channel_o,
  output logic                                 afe_diff_o,
  output logic      [1:0]                      afe_gain_o,
  output logic                                 afe_track_o,
  output logic                                 afe_hold_o,
  output logic                                 busy_o,
  output front_end_seq_pkg::seq_state_t        phase_o
);
  import front_end_seq_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [31:0] mode_reg;          // Timing and ordering fields
  logic [31:0] ext_reg;           // Compare, resolution and sign fields
  logic [31:0] seq_low;           // Slots 0..7
  logic [31:0] seq_high;          // Slots 8..15
  logic [15:0] chan_en;           // Channel or slot enables
  logic [31:0] cmp_window;        // High threshold above, low below
  logic [31:0] gain_reg;          // Two gain bits per channel
  logic [15:0] diff_reg;          // Differential select per channel
  logic        wprot_en;          // Write lock
  logic [15:0] last_data;         // Last stored result
  logic [3:0]  last_chan;         // Channel of the last result
  logic        data_ready;        // New result since last read
  logic        cmp_flag;          // Filtered compare event
  logic [1:0]  filt_cnt;          // Consecutive compare events
  logic [2:0]  trig_sync;         // Two sync stages plus edge history
  seq_state_t  state;             // Conversion phase
  logic [3:0]  slot;              // Current slot or channel index
  logic [4:0]  phase_cnt;         // Converter periods left in phase
  logic [15:0] div_cnt;           // Core clocks per converter period
  logic [8:0]  samp_cnt;          // Samples taken in single trigger mode
  logic [8:0]  pass_cnt;          // Passes taken in multi trigger mode
  logic [19:0] acc [16];          // Per-slot sample accumulators

  // Field views
  logic        user_order_en;
  logic        per_channel_analog_en;
  logic [4:0]  settle_len;
  logic [4:0]  track_len;
  logic [4:0]  xfer_len;
  logic [2:0]  res;
  logic        one_trigger_average;
  logic [8:0]  avg_n;
  logic [3:0]  cur_chan;
  logic        cur_diff;
  logic        cur_signed;

  // Bus decode
  logic        bus_done;
  logic        wr_ok;
  logic        mapped;
  logic [31:0] rd_data;

  // Sequencer helpers
  logic        tick;
  logic        trig_evt;
  logic [4:0]  first_slot;
  logic [4:0]  next_slot;
  logic        last_sample;
  logic        first_sample;
  logic [19:0] next_acc;
  logic [19:0] scaled;
  logic [4:0]  res_width;
  logic [15:0] result;
  logic        cmp_hit;
  logic        cmp_watch;

  ////////////////////////////////////////////////////////////////////////////
  // Field decode

  assign user_order_en         = mode_reg[`MODE_USER_ORDER_BIT];
  assign per_channel_analog_en = mode_reg[`MODE_PER_CHAN_BIT];
  assign res                   = ext_reg[`EXT_RES_LSB +: 3];
  assign one_trigger_average   = ext_reg[`EXT_ONE_TRIG_BIT];

  // Settling table
  always_comb
  begin
    unique case (mode_reg[`MODE_SETTLE_LSB +: 2])
      2'h0:    settle_len = `SETTLE_CODE0;
      2'h1:    settle_len = `SETTLE_CODE1;
      2'h2:    settle_len = `SETTLE_CODE2;
      default: settle_len = `SETTLE_CODE3;
    endcase
  end

  // Tracking and transfer lengths in converter periods
  assign track_len = {1'b0, mode_reg[`MODE_TRACK_LSB +: 4]} + 5'd1;
  assign xfer_len  = {2'b00, mode_reg[`MODE_XFER_LSB +: 2], 1'b0} + 5'd3;

  // Samples per result: 1 for plain codes, 4^(code-1) when averaging
  always_comb
  begin
    if (res > `RES_10BIT)
      avg_n = 9'd1 << (5'd2 * (5'(res) - 5'd1));
    else
      avg_n = 9'd1;
  end

  // Slot index maps to a channel only in user order
  always_comb
  begin
    if (!user_order_en)
      cur_chan = slot;
    else if (slot < 4'd8)
      cur_chan = seq_low[{slot[2:0], 2'b00} +: 4];
    else
      cur_chan = seq_high[{slot[2:0], 2'b00} +: 4];
  end

  // Channel zero settings stand in for all when per-channel change is off
  assign cur_diff = per_channel_analog_en ? diff_reg[cur_chan] : diff_reg[0];

  // Signedness per sign mode and channel type
  always_comb
  begin
    unique case (ext_reg[`EXT_SIGN_LSB +: 2])
      2'h0:    cur_signed = cur_diff;
      2'h1:    cur_signed = !cur_diff;
      2'h2:    cur_signed = 1'b0;
      default: cur_signed = 1'b1;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: one wait state, answer on the second access cycle

  assign bus_done = psel_i && penable_i && pready_o;
  assign wr_ok    = bus_done && pwrite_i && !wprot_en;

  // Read multiplexer and decode
  always_comb
  begin
    mapped  = 1'b1;
    rd_data = `RESET_ZERO;
    unique case (paddr_i)
      `OFS_MODE:         rd_data = mode_reg;
      `OFS_EXT_MODE:     rd_data = ext_reg;
      `OFS_SEQ_LOW:      rd_data = seq_low;
      `OFS_SEQ_HIGH:     rd_data = seq_high;
      `OFS_CHAN_SET:     rd_data = `RESET_ZERO;
      `OFS_CHAN_CLR:     rd_data = `RESET_ZERO;
      `OFS_CHAN_STATUS:  rd_data = {16'h0000, chan_en};
      `OFS_LAST_RESULT:  rd_data = {4'h0, last_chan, 8'h00, last_data};
      `OFS_EVENT_STATUS:
      begin
        rd_data[`STAT_DRDY_BIT] = data_ready;
        rd_data[`STAT_CMP_BIT]  = cmp_flag;
      end
      `OFS_CMP_WINDOW:   rd_data = cmp_window;
      `OFS_CHAN_GAIN:    rd_data = gain_reg;
      `OFS_CHAN_DIFF:    rd_data = {16'h0000, diff_reg};
      `OFS_WPROT:        rd_data[`WPROT_EN_BIT] = wprot_en;
      default:           mapped = 1'b0;  // Unmapped: error answer
    endcase
  end

  // Handshake and read data, all registered
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= `RESET_ZERO;
    end
    else if (ce_i)
    begin
      pready_o  <= psel_i && penable_i && !pready_o;
      pslverr_o <= psel_i && penable_i && !pready_o && !mapped;
      prdata_o  <= (psel_i && penable_i && !pready_o && !pwrite_i) ? rd_data : `RESET_ZERO;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers

  // Mode, ext and slot words lockable; window, gain, diff and the lock itself always writable
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      mode_reg   <= `RESET_ZERO;
      ext_reg    <= `RESET_ZERO;
      seq_low    <= `RESET_ZERO;
      seq_high   <= `RESET_ZERO;
      cmp_window <= `RESET_ZERO;
      gain_reg   <= `RESET_ZERO;
      diff_reg   <= 16'h0000;
      wprot_en   <= 1'b0;
    end
    else if (ce_i)
    begin
      if (wr_ok && paddr_i == `OFS_MODE)
        mode_reg <= pwdata_i & 32'hBBF0_0000;  // Implemented fields kept except track field bit 26; unused bit 22 kept too
      if (wr_ok && paddr_i == `OFS_EXT_MODE)
        ext_reg <= pwdata_i & 32'h3307_32F3;
      if (wr_ok && paddr_i == `OFS_SEQ_LOW)
        seq_low <= pwdata_i;
      if (wr_ok && paddr_i == `OFS_SEQ_HIGH)
        seq_high <= pwdata_i;
      if (bus_done && pwrite_i && paddr_i == `OFS_CMP_WINDOW)
        cmp_window <= pwdata_i;
      if (bus_done && pwrite_i && paddr_i == `OFS_CHAN_GAIN)
        gain_reg <= pwdata_i;
      if (bus_done && pwrite_i && paddr_i == `OFS_CHAN_DIFF)
        diff_reg <= pwdata_i[15:0];
      if (bus_done && pwrite_i && paddr_i == `OFS_WPROT)
        wprot_en <= pwdata_i[`WPROT_EN_BIT];
    end
  end

  // Channel enables: set and clear through separate write-only words
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      chan_en <= 16'h0000;
    else if (ce_i)
    begin
      if (wr_ok && paddr_i == `OFS_CHAN_SET)
        chan_en <= chan_en | pwdata_i[15:0];
      else if (wr_ok && paddr_i == `OFS_CHAN_CLR)
        chan_en <= chan_en & ~pwdata_i[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Trigger pin: two sync stages, edge taken after the second

  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      trig_sync <= 3'b000;
    else if (ce_i)
      trig_sync <= {trig_sync[1:0], trigger_i};
  end

  assign trig_evt = trig_sync[1] && !trig_sync[2];

  // Converter period divider, runs only during a conversion
  // Restarts on store, so the phase after it gets whole periods
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      div_cnt <= 16'h0000;
    else if (ce_i)
    begin
      if (state == ST_IDLE || state == ST_STORE || tick)
        div_cnt <= 16'h0000;
      else
        div_cnt <= div_cnt + 16'h0001;
    end
  end

  assign tick = (div_cnt == 16'(AFE_DIV - 1));

  ////////////////////////////////////////////////////////////////////////////
  // Slot search: lowest enabled index, and lowest enabled index above the current slot

  always_comb
  begin
    first_slot = 5'h10;
    next_slot  = 5'h10;
    for (int i = 15; i >= 0; i--)
    begin
      if (chan_en[i])
        first_slot = 5'(i);
      if (chan_en[i] && 5'(i) > {1'b0, slot})
        next_slot = 5'(i);
    end
  end

  // Averaging bookkeeping
  assign first_sample = one_trigger_average ? (samp_cnt == 9'd0) : (pass_cnt == 9'd0);
  assign last_sample  = one_trigger_average ? (samp_cnt == avg_n - 9'd1) : (pass_cnt == avg_n - 9'd1);
  assign next_acc     = (first_sample ? 20'h00000 : acc[slot]) + {8'h00, afe_result_i};

  ////////////////////////////////////////////////////////////////////////////
  // Result format: scale the sum, then sign or zero extend

  always_comb
  begin
    if (res == `RES_12BIT)
    begin
      scaled    = acc[slot];
      res_width = `RES_12BIT_WIDTH;
    end
    else if (res == `RES_10BIT)
    begin
      scaled    = acc[slot] >> `RES_10BIT_SHIFT;
      res_width = `RES_10BIT_WIDTH;
    end
    else
    begin
      scaled    = acc[slot] >> (5'(res) - 5'd1);
      res_width = `RES_AVG_BASE_WIDTH + 5'(res);
    end
    for (int b = 0; b < 16; b++)
      result[b] = (5'(b) < res_width) ? scaled[b] : (cur_signed && scaled[res_width - 5'd1]);
  end

  // Window test, signed when the result is signed
  always_comb
  begin
    logic lo;
    logic hi;
    lo = cur_signed ? ($signed(result) < $signed(cmp_window[15:0])) : (result < cmp_window[15:0]);
    hi = cur_signed ? ($signed(result) > $signed(cmp_window[31:16])) : (result > cmp_window[31:16]);
    unique case (cmp_mode_t'(ext_reg[`EXT_CMP_MODE_LSB +: 2]))
      CMP_LOW:  cmp_hit = lo;
      CMP_HIGH: cmp_hit = hi;
      CMP_IN:   cmp_hit = !lo && !hi;
      CMP_OUT:  cmp_hit = lo || hi;
    endcase
  end

  assign cmp_watch = ext_reg[`EXT_CMP_EVERY_BIT] || (cur_chan == ext_reg[`EXT_CMP_CHAN_LSB +: 4]);

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: settle, track, transfer, store for each slot

  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state     <= ST_IDLE;
      slot      <= 4'h0;
      phase_cnt <= 5'h00;
      samp_cnt  <= 9'h000;
      pass_cnt  <= 9'h000;
    end
    else if (ce_i)
    begin
      unique case (state)
        ST_IDLE:
          // Triggers while busy are ignored; one pass per trigger
          if (trig_evt && !first_slot[4])
          begin
            slot      <= first_slot[3:0];
            phase_cnt <= settle_len;
            samp_cnt  <= 9'h000;
            state     <= ST_SETTLE;
          end
        ST_SETTLE:
          if (tick && phase_cnt == 5'd1)
          begin
            phase_cnt <= track_len;
            state     <= ST_TRACK;
          end
          else if (tick)
            phase_cnt <= phase_cnt - 5'd1;
        ST_TRACK:
          if (tick && phase_cnt == 5'd1)
          begin
            phase_cnt <= xfer_len;
            state     <= ST_TRANSFER;
          end
          else if (tick)
            phase_cnt <= phase_cnt - 5'd1;
        ST_TRANSFER:
          if (tick && phase_cnt == 5'd1)
            state <= ST_STORE;
          else if (tick)
            phase_cnt <= phase_cnt - 5'd1;
        ST_STORE:
          if (one_trigger_average && !last_sample)
          begin
            // Same slot again without re-settling
            samp_cnt  <= samp_cnt + 9'd1;
            phase_cnt <= track_len;
            state     <= ST_TRACK;
          end
          else if (!next_slot[4])
          begin
            slot      <= next_slot[3:0];
            samp_cnt  <= 9'h000;
            phase_cnt <= settle_len;
            state     <= ST_SETTLE;
          end
          else
          begin
            // End of pass; multi-trigger averaging counts passes
            pass_cnt <= (one_trigger_average || last_sample) ? 9'h000 : pass_cnt + 9'd1;
            state    <= ST_IDLE;
          end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // Accumulate at the end of transfer
  always_ff @(posedge core_clk_i)
  begin
    if (ce_i && state == ST_TRANSFER && tick && phase_cnt == 5'd1)
      acc[slot] <= next_acc;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result store, tag and event flags

  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      last_data <= 16'h0000;
      last_chan <= 4'h0;
    end
    else if (ce_i && state == ST_STORE && last_sample)
    begin
      last_data <= result;
      last_chan <= ext_reg[`EXT_TAG_BIT] ? cur_chan : 4'h0;
    end
  end

  // Ready flag: cleared by reading the result, a new result wins
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      data_ready <= 1'b0;
    else if (ce_i)
    begin
      if (state == ST_STORE && last_sample)
        data_ready <= 1'b1;
      else if (bus_done && !pwrite_i && paddr_i == `OFS_LAST_RESULT)
        data_ready <= 1'b0;
    end
  end

  // Compare filter; flag cleared by a status read unless an event lands then
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      filt_cnt <= 2'b00;
      cmp_flag <= 1'b0;
    end
    else if (ce_i)
    begin
      if (state == ST_STORE && last_sample && cmp_watch && cmp_hit &&
          filt_cnt == ext_reg[`EXT_FILTER_LSB +: 2])
      begin
        filt_cnt <= 2'b00;
        cmp_flag <= 1'b1;
      end
      else
      begin
        if (state == ST_STORE && last_sample && cmp_watch)
          filt_cnt <= cmp_hit ? filt_cnt + 2'b01 : 2'b00;
        if (bus_done && !pwrite_i && paddr_i == `OFS_EVENT_STATUS)
          cmp_flag <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Analog controls, registered

  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      afe_channel_o <= 4'h0;
      afe_diff_o    <= 1'b0;
      afe_gain_o    <= 2'b00;
      afe_track_o   <= 1'b0;
      afe_hold_o    <= 1'b0;
      busy_o        <= 1'b0;
      phase_o       <= ST_IDLE;
    end
    else if (ce_i)
    begin
      afe_channel_o <= cur_chan;
      afe_diff_o    <= cur_diff;
      afe_gain_o    <= per_channel_analog_en ? gain_reg[{cur_chan, 1'b0} +: 2] : gain_reg[1:0];
      afe_track_o   <= (state == ST_TRACK);
      afe_hold_o    <= (state == ST_TRANSFER);
      busy_o        <= (state != ST_IDLE);
      phase_o       <= state;
    end
  end

endmodule // front_end_controller

`default_nettype wire

// ---- tb/fe_seq_sva.sv ----
/* Port checks of the front-end sequencer: bus handshake and phase order.
   Assumes binding to front_end_controller with one clock per converter period. */
`default_nettype none
module fe_seq_sva
  import front_end_seq_pkg::*;
(
  input wire logic        core_clk_i,
  input wire logic        arst_n_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        afe_track_o,
  input wire logic        busy_o,
  input wire seq_state_t  phase_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  ////////////////////////////////////////////////////////////////////////
  a_one_wait: assert property (psel_i && $rose(penable_i) |=> pready_o)
    else $error("ready late");
  a_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("ready held");
  a_rdata_quiet: assert property (!pready_o |-> prdata_o == 32'h0)
    else $error("read data outside answer");
  a_err_with_ready: assert property (pslverr_o |-> pready_o && prdata_o == 32'h0)
    else $error("error without ready");
  a_busy_phase: assert property (busy_o == (phase_o != ST_IDLE))
    else $error("busy disagrees with phase");
  a_settle_min: assert property (phase_o == ST_SETTLE && $past(phase_o) != ST_SETTLE
    |-> phase_o == ST_SETTLE [*3])
    else $error("settle too short");
  a_settle_next: assert property (phase_o == ST_SETTLE |=> phase_o inside {ST_SETTLE, ST_TRACK})
    else $error("bad phase after settle");
  a_track_seen: assert property (afe_track_o == (phase_o == ST_TRACK))
    else $error("track line missing");
  a_xfer_min: assert property (phase_o == ST_TRANSFER && $past(phase_o) != ST_TRANSFER
    |-> phase_o == ST_TRANSFER [*3])
    else $error("transfer too short");
  a_store_once: assert property (phase_o == ST_STORE |=> phase_o != ST_STORE)
    else $error("store too long");
  c_conv: cover property ($rose(busy_o));
  c_err: cover property (pslverr_o);
  c_track: cover property (afe_track_o);
endmodule // fe_seq_sva
`default_nettype wire

// ---- tb/afe_conv_model.sv ----
/* Converter on the far side: returns a code built from the channel.
   Assumes the hold line marks when the sample is valid. */
`default_nettype none
module afe_conv_model
(
  input  wire logic [3:0]  ch_i,
  input  wire logic        hold_i,
  output logic      [11:0] res_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Outside hold the inverse shows, so a stale sample never passes
  assign res_o = hold_i ? {ch_i, 8'h43} : ~{ch_i, 8'h43};
endmodule // afe_conv_model
`default_nettype wire

// ---- tb/tb_top.sv ----
/* Self-checking bench of the front-end sequencer over APB.
   Assumes the register header on the include path. */
`default_nettype none
`include "front_end_seq_regs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 0;
  logic        rst_n = 0;
  logic        psel = 0;
  logic        penable = 0;
  logic        pwrite = 0;
  logic        trig = 0;
  logic [31:0] paddr = 0;
  logic [31:0] pwdata = 0;
  logic [31:0] prdata;
  logic        pready, pslverr, track, hold, busy, diff;
  logic [3:0]  ch;
  logic [1:0]  gain;
  logic [11:0] res;
  front_end_seq_pkg::seq_state_t phase;
  int          num_errors = 0;
  int          n_checks = 0;
  int          cyc = 0;
  always #50 clk = ~clk;
  front_end_controller uut (.core_clk_i(clk), .arst_n_i(rst_n), .ce_i(1'h1), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .trigger_i(trig), .afe_result_i(res), .afe_channel_o(ch),
    .afe_diff_o(diff), .afe_gain_o(gain), .afe_track_o(track), .afe_hold_o(hold), .busy_o(busy),
    .phase_o(phase));
  afe_conv_model model (.ch_i(ch), .hold_i(hold), .res_o(res));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, exp, input string what);
    n_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One APB transfer, held until ready is sampled high
  task automatic apb(input logic w, input logic [31:0] a, d, output logic [31:0] q, output logic e);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [31:0] a, d);
    logic [31:0] q;
    logic        e;
    apb(1'h1, a, d, q, e);
  endtask
  task automatic rd(input logic [31:0] a, exp, input string what);
    logic [31:0] q;
    logic        e;
    apb(1'h0, a, 32'h0, q, e);
    chk(q, exp, what);
  endtask
  // One trigger pulse; counts busy cycles; channels untouched meanwhile
  task automatic conv(output logic [31:0] n);
    n = 0;
    trig <= 1'h1;
    for (int i = 0; i < 84; i++)
    begin
      @(posedge clk);
      n += busy;
      if (i == 3)
        trig <= 1'h0;
    end
  endtask
  task automatic end_of_test();
    if (num_errors == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      num_errors++;
      end_of_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic [31:0] q;
    logic        e;
    logic [31:0] n;
    int          st[4] = '{3, 5, 9, 17};
    logic [31:0] ra[6] = '{`OFS_EXT_MODE, `OFS_SEQ_LOW, `OFS_SEQ_HIGH, `OFS_CHAN_SET, `OFS_CHAN_CLR,
                           `OFS_CHAN_STATUS};
    repeat (5) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    foreach (ra[i]) rd(ra[i], 32'h0, "reset value");
    apb(1'h0, 32'h400B0040, 32'h0, q, e);
    chk({31'h0, e}, 32'h1, "unmapped error");
    wr(`OFS_SEQ_LOW, 32'hFEDCBA98);
    wr(`OFS_SEQ_HIGH, 32'h76543210);
    rd(`OFS_SEQ_LOW, 32'hFEDCBA98, "slots low");
    rd(`OFS_SEQ_HIGH, 32'h76543210, "slots high");
    wr(`OFS_CHAN_SET, 32'h15);
    wr(`OFS_CHAN_SET, 32'h0);
    wr(`OFS_CHAN_CLR, 32'h11);
    rd(`OFS_CHAN_STATUS, 32'h4, "channel status");
    wr(`OFS_WPROT, 32'h1);
    wr(`OFS_CHAN_SET, 32'h8);
    wr(`OFS_EXT_MODE, 32'hFFFF);
    rd(`OFS_CHAN_STATUS, 32'h4, "locked status");
    rd(`OFS_EXT_MODE, 32'h0, "locked ext mode");
    wr(`OFS_WPROT, 32'h0);
    wr(`OFS_CMP_WINDOW, 32'h01000000);
    wr(`OFS_EXT_MODE, 32'h31000201);
    for (int s = 0; s < 4; s++)
    begin
      wr(`OFS_MODE, (s << 20) | (2 << 24) | (1 << 28));
      conv(n);
      chk(n, st[s] + 3 + 5 + 1, "busy cycles");
    end
    rd(`OFS_EVENT_STATUS, 32'h05000000, "flags");
    rd(`OFS_LAST_RESULT, 32'h02000243, "tagged result");
    rd(`OFS_EVENT_STATUS, 32'h0, "flags cleared");
    wr(`OFS_CHAN_DIFF, 32'h4);
    wr(`OFS_CHAN_GAIN, 32'h30);
    @(posedge clk);
    chk({29'h0, diff, gain}, 32'h0, "shared analog");
    wr(`OFS_MODE, 32'h00800000);
    @(posedge clk);
    chk({29'h0, diff, gain}, 32'h7, "own analog");
    wr(`OFS_SEQ_LOW, 32'h00000F00);
    wr(`OFS_EXT_MODE, 32'h30000000);
    wr(`OFS_MODE, 32'h80000000);
    conv(n);
    chk(n, 8, "user pass cycles");
    rd(`OFS_EVENT_STATUS, 32'h01000000, "no compare");
    rd(`OFS_LAST_RESULT, 32'h0000FF43, "user result");
    wr(`OFS_EXT_MODE, 32'h22021203);
    conv(n);
    chk(n, 3 + 4 * (1 + 3 + 1), "averaged pass cycles");
    rd(`OFS_EVENT_STATUS, 32'h01000000, "filtered once");
    conv(n);
    rd(`OFS_EVENT_STATUS, 32'h05000000, "filtered twice");
    rd(`OFS_LAST_RESULT, 32'h00001E86, "averaged result");
    end_of_test();
  end
endmodule // tb_top
bind front_end_controller fe_seq_sva chk (.core_clk_i, .arst_n_i, .psel_i, .penable_i, .prdata_o,
  .pready_o, .pslverr_o, .afe_track_o, .busy_o, .phase_o);
`default_nettype wire
